// ===== hdl/eeslv_map.vh
// Constants for the serial EEPROM two-wire slave
`ifndef EESLV_MAP_VH
`define EESLV_MAP_VH
// APB register offsets and fields
`define REG_CTRL        12'h000
`define REG_STAT        12'h004
`define CTRL_RESET      1'h1
`define CTRL_LINK_EN    0
`define STAT_BUSY       0
`define STAT_ACTIVE     1
`define STAT_ROW_LSB    2
`define STAT_ROW_MSB    6
// Control byte layout
`define CB_ROW_MSB      7
`define CB_ROW_LSB      3
`define CB_MODE_HI      2
`define CB_MODE_LO      1
`define CB_RNW          0
// Word halves
`define HB_MSB          15
`define HB_LSB          8
`define LB_MSB          7
`define LB_LSB          0
// Geometry and counts
`define ROW_COUNT       32
`define ROW_STEP        5'h01
`define BYTE_BITS       4'h8
`define BIT_ONE         4'h1
`define BIT_ZERO        4'h0
`define WR_MAX          2'h2
`define WR_ONE          2'h1
`define WR_NONE         2'h0
`define MEM_RESET       16'h0000
`define WORD_ZERO       16'h0000
`define WORD_ONES       16'hffff
// Programming time
`define PROG_TIME_US    10000
`define CLK_FREQ_MHZ    10
`endif

// ===== hdl/eeslv_top.v
// Serial EEPROM two-wire slave, 32 rows of 16 bits, with APB control
//
// Operation
// - Data changes only with clock low; high-clock changes mean start or stop.
// - Data falling while clock high is a start, opening a transfer.
// - Data rising while clock high is a stop, ending a transfer.
// - Start leaves standby, stop returns to standby.
// - Receiver acknowledges each byte by holding data low in ninth pulse.
// - Missing master acknowledge stops sending; data is released until the next start or stop.
// - In standby the data line is released, never driven.
// - Control byte MSB first: row address, two mode bits, direction.
// - Addressed row word is loaded into a buffer on every access.
// - Writes take one or two data bytes; reads any number.
// - Write is start, control byte, up to two bytes, stop.
// - Stop after a write starts timed erase then program cycle.
// - While programming, control bytes get no acknowledge.
// - Write mode bits choose low-first or high-first byte order.
// - Read control byte is acknowledged, word loaded, first byte sent.
// - After both bytes and acknowledge, step row and load next word.
// - Read low-first increments row; high-first decrements row.
// - Row address wraps around during sequential reads.
// - Write control bytes with both mode bits equal (00 or 11, any row) set the whole memory to zeros or ones.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "eeslv_map.vh"
module eeslv_top
#(
   parameter PROG_CYCLES = `PROG_TIME_US * `CLK_FREQ_MHZ,
   parameter PCNT_W      = 17
)
(
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire        ce,
   input  wire        chip_link_clock_pad,
   input  wire        chip_link_data_pad_in,
   output reg         chip_link_data_pad_out,
   output reg         chip_link_data_pad_oe_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RX   = 3'h1;
   localparam [2:0] ST_ACK  = 3'h2;
   localparam [2:0] ST_TX   = 3'h3;
   localparam [2:0] ST_MACK = 3'h4;
   localparam [2:0] ST_WAIT = 3'h5;
   localparam [31:0] PROG_LAST  = PROG_CYCLES - 1;
   localparam [31:0] ERASE_LAST = PROG_CYCLES / 2 - 1;

   function [7:0] eeslv_sel_byte;
      input [15:0] w;
      input        hi;
      begin
         eeslv_sel_byte = hi ? w[`HB_MSB:`HB_LSB] : w[`LB_MSB:`LB_LSB];
      end
   endfunction

   reg        scl_s1;
   reg        scl_s2;
   reg        scl_s3;
   reg        sda_s1;
   reg        sda_s2;
   reg        sda_s3;
   reg [2:0]  state;
   reg [3:0]  bit_cnt;
   reg [7:0]  shift;
   reg [15:0] word_buf;
   reg [4:0]  row;
   reg        mode_hi;
   reg        is_read;
   reg        is_ctrl;
   reg        macked;
   reg        byte_idx;
   reg [1:0]  wr_cnt;
   reg        prog_pend;
   reg        init_zero;
   reg        init_one;
   reg        busy;
   reg [PCNT_W-1:0] pcnt;
   reg        link_en;
   reg [15:0] mem [0:`ROW_COUNT-1];
   integer    i;

   wire scl_rise = scl_s2 & ~scl_s3;
   wire scl_fall = ~scl_s2 & scl_s3;
   wire scl_high = scl_s2 & scl_s3;
   wire start_det = scl_high & sda_s3 & ~sda_s2;
   wire stop_det = scl_high & ~sda_s3 & sda_s2;
   wire [31:0] pcnt_ext = {{(32-PCNT_W){1'b0}}, pcnt};
   wire [4:0] next_row = mode_hi ? row - `ROW_STEP : row + `ROW_STEP;
   wire [15:0] next_word = mem[next_row];
   wire [7:0] next_tx = byte_idx ? eeslv_sel_byte(next_word, mode_hi)
                                 : eeslv_sel_byte(word_buf, ~mode_hi);
   wire [7:0] first_tx = eeslv_sel_byte(word_buf, mode_hi);
   wire wr_hi = mode_hi ^ wr_cnt[0];
   wire init_code = ~shift[`CB_RNW] &
                    (shift[`CB_MODE_HI] == shift[`CB_MODE_LO]);
   wire prog_go = prog_pend | init_zero | init_one;
   wire apb_go = psel & penable & pready;
   wire [31:0] stat_word = {{(32-`STAT_ROW_MSB-1){1'b0}}, row,
                            (state != ST_IDLE), busy};

   // Pins pass two flops; third stage only for edge finding
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
      end
      else if (ce)
      begin
         scl_s1 <= chip_link_clock_pad;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= chip_link_data_pad_in;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
      end
   end

   // APB slave, one wait state per transfer
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         link_en <= `CTRL_RESET;
      end
      else if (ce)
      begin
         pready <= psel & penable & ~pready;
         if (psel & penable & ~pready)
         begin
            pslverr <= (paddr != `REG_CTRL) & (paddr != `REG_STAT);
            if (paddr == `REG_CTRL)
               prdata <= {31'h0000_0000, link_en};
            else if (paddr == `REG_STAT)
               prdata <= stat_word;
            else
               prdata <= 32'h0000_0000;
         end
         if (apb_go & pwrite & (paddr == `REG_CTRL))
            link_en <= pwdata[`CTRL_LINK_EN];
      end
   end

   // Link protocol and programming engine
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         chip_link_data_pad_out  <= 1'b0;
         chip_link_data_pad_oe_n <= 1'b1;
         state     <= ST_IDLE;
         bit_cnt   <= `BIT_ZERO;
         shift     <= 8'h00;
         word_buf  <= `WORD_ZERO;
         row       <= 5'h00;
         mode_hi   <= 1'b0;
         is_read   <= 1'b0;
         is_ctrl   <= 1'b0;
         macked    <= 1'b0;
         byte_idx  <= 1'b0;
         wr_cnt    <= `WR_NONE;
         prog_pend <= 1'b0;
         init_zero <= 1'b0;
         init_one  <= 1'b0;
         busy      <= 1'b0;
         pcnt      <= {PCNT_W{1'b0}};
         for (i = 0; i < `ROW_COUNT; i = i + 1)
            mem[i] <= `MEM_RESET;
      end
      else if (ce)
      begin
         chip_link_data_pad_out <= 1'b0;
         if (busy)
         begin
            pcnt <= pcnt + {{(PCNT_W-1){1'b0}}, 1'b1};
            if (pcnt_ext == ERASE_LAST)
            begin
               if (init_zero | init_one)
                  for (i = 0; i < `ROW_COUNT; i = i + 1)
                     mem[i] <= `WORD_ZERO;
               else
                  mem[row] <= `WORD_ZERO;
            end
            if (pcnt_ext == PROG_LAST)
            begin
               busy <= 1'b0;
               if (init_one)
                  for (i = 0; i < `ROW_COUNT; i = i + 1)
                     mem[i] <= `WORD_ONES;
               else if (~init_zero)
                  mem[row] <= word_buf;
               init_zero <= 1'b0;
               init_one  <= 1'b0;
               prog_pend <= 1'b0;
            end
         end
         if (~link_en)
         begin
            state <= ST_IDLE;
            chip_link_data_pad_oe_n <= 1'b1;
         end
         else if (stop_det)
         begin
            state <= ST_IDLE;
            chip_link_data_pad_oe_n <= 1'b1;
            if (prog_go & ~busy)
            begin
               busy <= 1'b1;
               pcnt <= {PCNT_W{1'b0}};
            end
         end
         else if (start_det)
         begin
            state   <= ST_RX;
            is_ctrl <= 1'b1;
            bit_cnt <= `BIT_ZERO;
            chip_link_data_pad_oe_n <= 1'b1;
         end
         else
         begin
            case (state)
               ST_IDLE:
               begin
                  chip_link_data_pad_oe_n <= 1'b1;
               end
               ST_RX:
               begin
                  if (scl_rise & (bit_cnt != `BYTE_BITS))
                  begin
                     shift   <= {shift[6:0], sda_s2};
                     bit_cnt <= bit_cnt + `BIT_ONE;
                  end
                  if (scl_fall & (bit_cnt == `BYTE_BITS))
                  begin
                     if (is_ctrl)
                     begin
                        if (busy)
                           state <= ST_WAIT;
                        else
                        begin
                           row     <= shift[`CB_ROW_MSB:`CB_ROW_LSB];
                           mode_hi <= shift[`CB_MODE_HI];
                           is_read <= shift[`CB_RNW];
                           word_buf <= mem[shift[`CB_ROW_MSB:`CB_ROW_LSB]];
                           init_zero <= init_code & ~shift[`CB_MODE_HI];
                           init_one  <= init_code & shift[`CB_MODE_HI];
                           wr_cnt    <= `WR_NONE;
                           byte_idx  <= 1'b0;
                           chip_link_data_pad_oe_n <= 1'b0;
                           state <= ST_ACK;
                        end
                     end
                     else if (wr_cnt == `WR_MAX)
                        state <= ST_WAIT;
                     else
                     begin
                        if (wr_hi)
                           word_buf[`HB_MSB:`HB_LSB] <= shift;
                        else
                           word_buf[`LB_MSB:`LB_LSB] <= shift;
                        wr_cnt    <= wr_cnt + `WR_ONE;
                        prog_pend <= 1'b1;
                        chip_link_data_pad_oe_n <= 1'b0;
                        state <= ST_ACK;
                     end
                  end
               end
               ST_ACK:
               begin
                  // at end of ack pulse, release, or on a read drive the first bit
                  if (scl_fall)
                  begin
                     is_ctrl <= 1'b0;
                     bit_cnt <= `BIT_ZERO;
                     if (is_read)
                     begin
                        shift   <= first_tx;
                        chip_link_data_pad_oe_n <= first_tx[7];
                        bit_cnt <= `BIT_ONE;
                        state   <= ST_TX;
                     end
                     else
                     begin
                        chip_link_data_pad_oe_n <= 1'b1;
                        state <= ST_RX;
                     end
                  end
               end
               ST_TX:
               begin
                  if (scl_fall)
                  begin
                     if (bit_cnt == `BYTE_BITS)
                     begin
                        chip_link_data_pad_oe_n <= 1'b1;
                        macked <= 1'b0;
                        state  <= ST_MACK;
                     end
                     else
                     begin
                        chip_link_data_pad_oe_n <= shift[6];
                        shift   <= {shift[6:0], 1'b0};
                        bit_cnt <= bit_cnt + `BIT_ONE;
                     end
                  end
               end
               ST_MACK:
               begin
                  if (scl_rise)
                  begin
                     if (sda_s2)
                        state <= ST_WAIT;
                     else
                        macked <= 1'b1;
                  end
                  if (scl_fall & macked)
                  begin
                     byte_idx <= ~byte_idx;
                     if (byte_idx)
                     begin
                        row      <= next_row;
                        word_buf <= next_word;
                     end
                     shift   <= next_tx;
                     chip_link_data_pad_oe_n <= next_tx[7];
                     bit_cnt <= `BIT_ONE;
                     state   <= ST_TX;
                  end
               end
               ST_WAIT:
               begin
                  chip_link_data_pad_oe_n <= 1'b1;
               end
               default:
               begin
                  state <= ST_IDLE;
                  chip_link_data_pad_oe_n <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// ===== sim/eeslv_top_assertions.sv
// Port checker for the two-wire slave and its register bus
`timescale 1ns/10ps
`default_nettype none
module eeslv_chk
#(
   parameter PROG_CYCLES = 100000,
   parameter PCNT_W      = 17
)
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        ce,
   input wire logic        chip_link_clock_pad,
   input wire logic        chip_link_data_pad_in,
   input wire logic        chip_link_data_pad_out,
   input wire logic        chip_link_data_pad_oe_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   AST_OUT_LOW: assert property (chip_link_data_pad_out == 1'h0)
      else $error("data output not low");
   AST_OE_CLK_LOW: assert property ($changed(chip_link_data_pad_oe_n) |->
      !$past(chip_link_clock_pad) && !$past(chip_link_clock_pad, 2))
      else $error("data enable moved with clock high");
   AST_ACK_HOLD: assert property ($fell(chip_link_data_pad_oe_n) |=>
      !chip_link_data_pad_oe_n [*5])
      else $error("low drive too short");
   // Stop leaves the line released well into idle
   AST_STOP_REL: assert property ($rose(chip_link_data_pad_in) && chip_link_clock_pad |=>
      chip_link_data_pad_oe_n [*8])
      else $error("line driven after stop");
   AST_PREADY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_PREADY_TAKEN: assert property (psel && penable && !pready |=> pready)
      else $error("ready late");
   AST_ERR_MAP: assert property (pready |->
      pslverr == ($past(paddr) != 12'h000 && $past(paddr) != 12'h004))
      else $error("error flag wrong for address");
   AST_ERR_ZERO: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
      else $error("error read data not zero");
   cover property (pready && pslverr);
   cover property ($fell(chip_link_data_pad_oe_n));
   cover property (pready && !pwrite);
endmodule
bind eeslv_top eeslv_chk #(.PROG_CYCLES(PROG_CYCLES), .PCNT_W(PCNT_W)) eeslv_chk_i
(
   .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .chip_link_clock_pad(chip_link_clock_pad),
   .chip_link_data_pad_in(chip_link_data_pad_in),
   .chip_link_data_pad_out(chip_link_data_pad_out),
   .chip_link_data_pad_oe_n(chip_link_data_pad_oe_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr)
);
`default_nettype wire

// ===== sim/eeslv_mst.sv
// Link master model: clock and data driver of the two-wire link
`timescale 1ns/10ps
`default_nettype none
module eeslv_mst
(
   input  wire logic clk_sys,
   output var logic  scl,
   output var logic  sda_m,
   input  wire logic sda
);
   // Clock idles high between frames
   initial
   begin
      scl <= 1'h1;
      sda_m <= 1'h1;
   end
   // link rate set by step counts
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic bitx(input logic b, output logic r);
      sda_m <= b;
      tick(2);
      scl <= 1'h1;
      tick(2);
      r = sda;
      tick(2);
      scl <= 1'h0;
      tick(2);
   endtask
   task automatic start;
      sda_m <= 1'h1;
      tick(2);
      scl <= 1'h1;
      tick(4);
      sda_m <= 1'h0;
      tick(4);
      scl <= 1'h0;
      tick(2);
   endtask
   task automatic stop;
      sda_m <= 1'h0;
      tick(2);
      scl <= 1'h1;
      tick(4);
      sda_m <= 1'h1;
      tick(4);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r);
      bitx(1'h1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(1'h1, d[i]);
      bitx(!more, r);
   endtask
endmodule
`default_nettype wire

// ===== sim/eeslv_top_tb.sv
// Self-checking bench for the two-wire serial EEPROM slave
`timescale 1ns/10ps
`default_nettype none
module eeslv_top_tb;
   typedef struct packed {logic [1:0] m; logic [4:0] r; logic [15:0] d; logic [15:0] w;} eeslv_row_t;
   logic        clk_sys = 1'h0;
   logic        rst_n = 1'h0;
   logic        ce = 1'h1;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] q;
   logic [2:0]  ak;
   logic        a;
   logic        e;
   int          mismatches = 0;
   int          comparisons = 0;
   wire  [31:0] prdata;
   wire         pready, pslverr, scl, sda_m, d_out, oe_n;
   wire         sda = sda_m & (oe_n | d_out);
   eeslv_row_t  rows [3] = '{'{2'h1, 5'h03, 16'h1234, 16'h3412},
      '{2'h2, 5'h04, 16'habcd, 16'habcd}, '{2'h1, 5'h1f, 16'h5aa5, 16'ha55a}};
   eeslv_top #(.PROG_CYCLES(200)) eeslv_top_i
   (
      .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .chip_link_clock_pad(scl),
      .chip_link_data_pad_in(sda), .chip_link_data_pad_out(d_out),
      .chip_link_data_pad_oe_n(oe_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
   );
   eeslv_mst eeslv_mst_i (.clk_sys(clk_sys), .scl(scl), .sda_m(sda_m), .sda(sda));
   always #50 clk_sys = !clk_sys;
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x)
      begin
         mismatches++;
         $display("unexpected at %0t: saw %h want %h", $time, s, x);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Request held until ready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      int t;
      @(posedge clk_sys);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'h1;
      t = 0;
      do
      begin
         @(posedge clk_sys);
         t++;
      end
      while (pready !== 1'h1 && t < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (t >= 20)
         mismatches++;
   endtask
   task automatic wr(input logic [4:0] r, input logic [1:0] m, input int n, input logic [23:0] d);
      int k;
      eeslv_mst_i.start();
      eeslv_mst_i.wbyte({r, m, 1'h0}, a);
      chk(a, 1);
      ak = 3'h0;
      for (int i = 0; i < n; i++)
         eeslv_mst_i.wbyte(d[23 - 8 * i -: 8], ak[2 - i]);
      eeslv_mst_i.stop();
      apb(1'h0, 12'h004, 32'h0000_0000);
      chk(q[0], 1);
      k = 0;
      a = 1'h0;
      // Poll with a plain mode so no init code fires
      // poll until acknowledged
      while (a !== 1'h1 && k < 20)
      begin
         eeslv_mst_i.start();
         eeslv_mst_i.wbyte({r, 2'h1, 1'h0}, a);
         eeslv_mst_i.stop();
         k++;
      end
      chk(k > 1 && a === 1'h1, 1);
   endtask
   task automatic rd(input logic [4:0] r, input logic [1:0] m, input int n);
      logic [7:0] b;
      eeslv_mst_i.start();
      eeslv_mst_i.wbyte({r, m, 1'h1}, a);
      chk(a, 1);
      q = 32'h0000_0000;
      for (int i = 0; i < n; i++)
      begin
         eeslv_mst_i.rbyte(i < n - 1, b);
         q = {q[23:0], b};
      end
      repeat (3) @(posedge clk_sys);
      chk(oe_n, 1);
      eeslv_mst_i.stop();
   endtask
   initial
   begin
      #4_000_000;
      mismatches++;
      end_sim();
   end
   initial
   begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk_sys);
      apb(1'h0, 12'h000, 32'h0000_0000);
      chk(q, 32'h0000_0001);
      apb(1'h0, 12'h004, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      chk(oe_n, 1);
      apb(1'h0, 12'h008, 32'h0000_0000);
      chk({e, q[30:0]}, 32'h8000_0000);
      $display("test reset done");
      foreach (rows[i])
      begin
         wr(rows[i].r, rows[i].m, 2, {rows[i].d, 8'h00});
         chk(ak, 3'h6);
         rd(rows[i].r, 2'h1, 2);
         chk(q, {16'h0000, rows[i].w[7:0], rows[i].w[15:8]});
      end
      rd(5'h1f, 2'h1, 3);
      chk(q, 32'h005a_a500);
      rd(5'h04, 2'h2, 4);
      chk(q, 32'habcd_3412);
      $display("test sequential done");
      wr(5'h03, 2'h2, 1, 24'hff_0000);
      rd(5'h03, 2'h1, 2);
      chk(q, 32'h0000_12ff);
      wr(5'h06, 2'h1, 3, 24'h11_2233);
      chk(ak, 3'h6);
      rd(5'h06, 2'h1, 2);
      chk(q, 32'h0000_1122);
      wr(5'h09, 2'h3, 0, 24'h00_0000);
      rd(5'h09, 2'h1, 2);
      chk(q, 32'h0000_ffff);
      wr(5'h09, 2'h0, 0, 24'h00_0000);
      rd(5'h04, 2'h2, 2);
      chk(q, 32'h0000_0000);
      apb(1'h1, 12'h000, 32'h0000_0000);
      eeslv_mst_i.start();
      eeslv_mst_i.wbyte(8'h02, a);
      eeslv_mst_i.stop();
      chk(a, 0);
      // Mid-run reset brings link enable back
      rst_n <= 1'h0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk_sys);
      apb(1'h0, 12'h000, 32'h0000_0000);
      chk(q, 32'h0000_0001);
      $display("test refusals done");
      // Frozen clock enable hides a whole frame
      ce <= 1'h0;
      eeslv_mst_i.start();
      eeslv_mst_i.wbyte(8'h1a, a);
      eeslv_mst_i.stop();
      ce <= 1'h1;
      chk(a, 0);
      apb(1'h0, 12'h004, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      $display("test clock enable done");
      end_sim();
   end
endmodule
`default_nettype wire
